/* common/dacc_pkg.sv */
// package: constants, register map and types of the dac host controller
package dacc_pkg;

    // system clock period
    localparam int CLK_NS = 8;

    // pin timing as driven by the host
    localparam int STROBE_LO_NS = 40;
    localparam int STROBE_HI_NS = 40;
    localparam int LOAD_NS      = 40;
    localparam int CLEAR_NS     = 40;
    localparam int CAL_NS       = 64;
    localparam int QUERY_NS     = 200;

    // least times round up to whole cycles, never below one
    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam logic [7:0] STROBE_LO_CYC = 8'(ns_to_cyc(STROBE_LO_NS));
    localparam logic [7:0] STROBE_HI_CYC = 8'(ns_to_cyc(STROBE_HI_NS));
    localparam logic [7:0] LOAD_CYC      = 8'(ns_to_cyc(LOAD_NS));
    localparam logic [7:0] CLEAR_CYC     = 8'(ns_to_cyc(CLEAR_NS));
    localparam logic [7:0] CAL_CYC       = 8'(ns_to_cyc(CAL_NS));
    localparam logic [7:0] QUERY_CYC     = 8'(ns_to_cyc(QUERY_NS));

    // register byte addresses
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_DATA   = 8'h04;
    localparam logic [7:0] ADDR_CMD    = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_CHAIN  = 8'h10;

    // control field positions
    localparam int CTRL_SERIAL    = 0;
    localparam int CTRL_MSB_FIRST = 1;
    localparam int CTRL_LEN18     = 2;
    localparam int CTRL_CLR_MID   = 3;
    localparam int CTRL_AUTO_LOAD = 4;
    localparam int CTRL_CAL_PREP  = 5;
    localparam int CTRL_W         = 6;
    localparam logic [5:0] CTRL_RESET = 6'h03;

    // command bits
    localparam int CMD_SEND  = 0;
    localparam int CMD_LOAD  = 1;
    localparam int CMD_CLEAR = 2;
    localparam int CMD_CAL   = 3;
    localparam int CMD_QUERY = 4;

    // word sizes and counts
    localparam int WORD_W = 18;
    localparam logic [4:0] LAST_BIT16 = 5'h0f;
    localparam logic [4:0] LAST_BIT18 = 5'h11;
    localparam logic [4:0] LAST_BYTE  = 5'h01;
    localparam int BYTE_HI = 8;

    // serial-mode pin positions on the data bus
    localparam int PIN_SDATA = 0;
    localparam int PIN_ORDER = 1;
    localparam int PIN_LEN   = 2;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_STROBE_LO,
        ST_STROBE_HI,
        ST_LOAD,
        ST_CLEAR,
        ST_CAL,
        ST_QUERY
    } dacc_state_t;

    // pins driven toward the converter
    typedef struct packed {
        logic       cs_n;
        logic [7:0] data;
        logic       serial_select_n;
        logic       high_byte_enable_n;
        logic       low_byte_enable_n;
        logic       clear_n;
        logic       calibrate_request_n;
        logic       second_rank_load;
    } dacc_pins_t;

    // pins read back from the converter
    typedef struct packed {
        logic calibration_valid;
        logic serial_out_chain;
    } dacc_in_t;

    // two-stage synchroniser state
    typedef struct packed {
        dacc_in_t meta;
        dacc_in_t stable;
    } dacc_sync_t;

endpackage

/* hdl/dacc_sync.sv */
// two-flop synchroniser for the converter's status pins
`timescale 1ns/10ps
module dacc_sync (
    input  wire logic             sys_clk,
    input  wire logic             reset_n,
    input  wire dacc_pkg::dacc_in_t pins_async,
    output dacc_pkg::dacc_in_t    pins_sync
);

    dacc_pkg::dacc_sync_t s_reg;
    dacc_pkg::dacc_sync_t s_next;

    // first stage feeds only the second stage
    always_comb
    begin
        s_next.meta   = pins_async;
        s_next.stable = s_reg.meta;
    end

    // state register
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    assign pins_sync = s_reg.stable;

endmodule

/* hdl/dacc_host.sv */
// host-side controller driving the serial/byte loading pins of a calibrating dac
//
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/10ps
// How it works
// - host pulses calibrate_request_n low; converter then lowers calibration_valid.
// - data_bit2 picks 16 or 18 bits; unused data pins driven low.
// - each chained converter needs its own load unless updated together.
// - in byte mode host drives clear target level whenever clear asserts.
// - with CTRL_CAL_PREP set, host loads zeros into first rank before calibrating.
// - host should program negative full scale before calibrating.
module dacc_host (
    input  wire logic                 sys_clk,
    input  wire logic                 reset_n,
    input  wire logic [7:0]           reg_addr,
    input  wire logic [31:0]          reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic [31:0]               reg_rdata,
    output dacc_pkg::dacc_pins_t      dac_pins,
    input  wire dacc_pkg::dacc_in_t   dac_status
);

    typedef struct packed {
        dacc_pkg::dacc_state_t  fsm;
        dacc_pkg::dacc_pins_t   pins;
        logic [5:0]             ctrl;
        logic [17:0]            data;
        logic [17:0]            chain;
        logic [7:0]             timer;
        logic [4:0]             bitcnt;
        logic                   pend_cal;
        logic                   query_res;
        logic                   query_done;
        logic [31:0]            rdata;
    } dacc_host_t;

    dacc_host_t         s_reg;
    dacc_host_t         s_next;
    dacc_pkg::dacc_in_t st_sync;

    // status pins cross into the system clock domain
    dacc_sync u_sync (
        .sys_clk    (sys_clk),
        .reset_n    (reset_n),
        .pins_async (dac_status),
        .pins_sync  (st_sync)
    );

    // resting pin levels for the current mode
    function automatic dacc_pkg::dacc_pins_t idle_pins(input logic [5:0] ctrl);
        dacc_pkg::dacc_pins_t p;
        p                     = '0;
        p.cs_n                = 1'b1;
        p.serial_select_n     = ~ctrl[dacc_pkg::CTRL_SERIAL];
        p.high_byte_enable_n  = 1'b1;
        p.clear_n             = 1'b1;
        p.calibrate_request_n = 1'b1;
        p.second_rank_load    = 1'b0;
        if (ctrl[dacc_pkg::CTRL_SERIAL])
        begin
            p.low_byte_enable_n           = ctrl[dacc_pkg::CTRL_CLR_MID];
            p.data[dacc_pkg::PIN_ORDER]   = ctrl[dacc_pkg::CTRL_MSB_FIRST];
            p.data[dacc_pkg::PIN_LEN]     = ctrl[dacc_pkg::CTRL_LEN18];
        end
        else
            p.low_byte_enable_n = 1'b1;
        return p;
    endfunction

    // pins for the low phase of strobe number idx
    function automatic dacc_pkg::dacc_pins_t strobe_pins(
        input logic [5:0]  ctrl,
        input logic [17:0] data,
        input logic [4:0]  idx
    );
        dacc_pkg::dacc_pins_t p;
        logic [4:0]           pos;
        p      = idle_pins(ctrl);
        p.cs_n = 1'b0;
        pos    = '0;
        if (ctrl[dacc_pkg::CTRL_SERIAL])
        begin
            // msb first counts down from the top of the chosen length
            if (ctrl[dacc_pkg::CTRL_MSB_FIRST])
                pos = (ctrl[dacc_pkg::CTRL_LEN18] ? dacc_pkg::LAST_BIT18
                                                  : dacc_pkg::LAST_BIT16) - idx;
            else
                pos = idx;
            p.data[dacc_pkg::PIN_SDATA] = data[pos];
        end
        else if (idx == '0)
        begin
            p.high_byte_enable_n = 1'b0;
            p.data               = data[dacc_pkg::BYTE_HI +: 8];
        end
        else
        begin
            p.low_byte_enable_n = 1'b0;
            p.data              = data[7:0];
        end
        return p;
    endfunction

    // last strobe index of a word
    function automatic logic [4:0] last_idx(input logic [5:0] ctrl);
        if (!ctrl[dacc_pkg::CTRL_SERIAL])
            return dacc_pkg::LAST_BYTE;
        return ctrl[dacc_pkg::CTRL_LEN18] ? dacc_pkg::LAST_BIT18
                                          : dacc_pkg::LAST_BIT16;
    endfunction

    logic busy;
    logic cmd_wr;
    assign busy   = (s_reg.fsm != dacc_pkg::ST_IDLE);
    assign cmd_wr = reg_wr && (reg_addr == dacc_pkg::ADDR_CMD) && !busy;

    // next-state logic: register port and pin sequencer
    always_comb
    begin
        s_next       = s_reg;
        s_next.rdata = '0;
        // read data stands in the cycle after the read strobe
        if (reg_rd)
        begin
            unique case (reg_addr)
                dacc_pkg::ADDR_CTRL:   s_next.rdata = 32'(s_reg.ctrl);
                dacc_pkg::ADDR_DATA:   s_next.rdata = 32'(s_reg.data);
                dacc_pkg::ADDR_STATUS: s_next.rdata = 32'({s_reg.query_done,
                                                          s_reg.query_res,
                                                          st_sync.calibration_valid,
                                                          busy});
                dacc_pkg::ADDR_CHAIN:  s_next.rdata = 32'(s_reg.chain);
                default:               s_next.rdata = '0;
            endcase
        end
        // configuration and data change only between transfers
        if (reg_wr && !busy && reg_addr == dacc_pkg::ADDR_CTRL)
            s_next.ctrl = reg_wdata[dacc_pkg::CTRL_W-1:0];
        if (reg_wr && !busy && reg_addr == dacc_pkg::ADDR_DATA)
            s_next.data = reg_wdata[dacc_pkg::WORD_W-1:0];

        unique case (s_reg.fsm)
            dacc_pkg::ST_IDLE:
            begin
                s_next.pins = idle_pins(s_reg.ctrl);
                if (cmd_wr && reg_wdata[dacc_pkg::CMD_SEND])
                begin
                    s_next.pins   = strobe_pins(s_reg.ctrl, s_reg.data, '0);
                    s_next.bitcnt = '0;
                    s_next.timer  = dacc_pkg::STROBE_LO_CYC - 8'h01;
                    s_next.fsm    = dacc_pkg::ST_STROBE_LO;
                end
                else if (cmd_wr && reg_wdata[dacc_pkg::CMD_LOAD])
                begin
                    s_next.pins.second_rank_load = 1'b1;
                    s_next.timer = dacc_pkg::LOAD_CYC - 8'h01;
                    s_next.fsm   = dacc_pkg::ST_LOAD;
                end
                else if (cmd_wr && reg_wdata[dacc_pkg::CMD_CLEAR])
                begin
                    s_next.pins.clear_n           = 1'b0;
                    s_next.pins.low_byte_enable_n = s_reg.ctrl[dacc_pkg::CTRL_CLR_MID];
                    s_next.timer = dacc_pkg::CLEAR_CYC - 8'h01;
                    s_next.fsm   = dacc_pkg::ST_CLEAR;
                end
                else if (cmd_wr && reg_wdata[dacc_pkg::CMD_CAL]
                         && s_reg.ctrl[dacc_pkg::CTRL_CAL_PREP])
                begin
                    // park the first rank at negative full scale first
                    s_next.data     = '0;
                    s_next.pend_cal = 1'b1;
                    s_next.pins     = strobe_pins(s_reg.ctrl, '0, '0);
                    s_next.bitcnt   = '0;
                    s_next.timer    = dacc_pkg::STROBE_LO_CYC - 8'h01;
                    s_next.fsm      = dacc_pkg::ST_STROBE_LO;
                end
                else if (cmd_wr && reg_wdata[dacc_pkg::CMD_CAL])
                begin
                    s_next.pins.calibrate_request_n = 1'b0;
                    s_next.timer = dacc_pkg::CAL_CYC - 8'h01;
                    s_next.fsm   = dacc_pkg::ST_CAL;
                end
                else if (cmd_wr && reg_wdata[dacc_pkg::CMD_QUERY])
                begin
                    s_next.pins.high_byte_enable_n = 1'b0;
                    s_next.query_done = 1'b0;
                    s_next.timer = dacc_pkg::QUERY_CYC - 8'h01;
                    s_next.fsm   = dacc_pkg::ST_QUERY;
                end
            end
            dacc_pkg::ST_STROBE_LO:
            begin
                s_next.timer = s_reg.timer - 8'h01;
                if (s_reg.timer == '0)
                begin
                    s_next.pins.cs_n = 1'b1;
                    s_next.timer     = dacc_pkg::STROBE_HI_CYC - 8'h01;
                    s_next.fsm       = dacc_pkg::ST_STROBE_HI;
                end
            end
            dacc_pkg::ST_STROBE_HI:
            begin
                s_next.timer = s_reg.timer - 8'h01;
                if (s_reg.timer == '0)
                begin
                    // collect what the converter shifted out of its far end
                    s_next.chain = {s_reg.chain[16:0], st_sync.serial_out_chain};
                    if (s_reg.bitcnt == last_idx(s_reg.ctrl))
                    begin
                        if (s_reg.ctrl[dacc_pkg::CTRL_AUTO_LOAD] || s_reg.pend_cal)
                        begin
                            s_next.pins.second_rank_load = 1'b1;
                            s_next.timer = dacc_pkg::LOAD_CYC - 8'h01;
                            s_next.fsm   = dacc_pkg::ST_LOAD;
                        end
                        else
                            s_next.fsm = dacc_pkg::ST_IDLE;
                    end
                    else
                    begin
                        s_next.bitcnt = s_reg.bitcnt + 5'h01;
                        s_next.pins   = strobe_pins(s_reg.ctrl, s_reg.data,
                                                    s_reg.bitcnt + 5'h01);
                        s_next.timer  = dacc_pkg::STROBE_LO_CYC - 8'h01;
                        s_next.fsm    = dacc_pkg::ST_STROBE_LO;
                    end
                end
            end
            dacc_pkg::ST_LOAD:
            begin
                s_next.timer = s_reg.timer - 8'h01;
                if (s_reg.timer == '0)
                begin
                    s_next.pins.second_rank_load = 1'b0;
                    if (s_reg.pend_cal)
                    begin
                        // calibrate only once the parked word is loaded
                        s_next.pend_cal                 = 1'b0;
                        s_next.pins.calibrate_request_n = 1'b0;
                        s_next.timer = dacc_pkg::CAL_CYC - 8'h01;
                        s_next.fsm   = dacc_pkg::ST_CAL;
                    end
                    else
                        s_next.fsm = dacc_pkg::ST_IDLE;
                end
            end
            dacc_pkg::ST_CLEAR:
            begin
                s_next.timer = s_reg.timer - 8'h01;
                if (s_reg.timer == '0)
                begin
                    s_next.pins.clear_n = 1'b1;
                    s_next.fsm          = dacc_pkg::ST_IDLE;
                end
            end
            dacc_pkg::ST_CAL:
            begin
                s_next.timer = s_reg.timer - 8'h01;
                if (s_reg.timer == '0)
                begin
                    s_next.pins.calibrate_request_n = 1'b1;
                    s_next.fsm = dacc_pkg::ST_IDLE;
                end
            end
            dacc_pkg::ST_QUERY:
            begin
                s_next.timer = s_reg.timer - 8'h01;
                if (s_reg.timer == '0)
                begin
                    s_next.query_res  = st_sync.calibration_valid;
                    s_next.query_done = 1'b1;
                    s_next.pins.high_byte_enable_n = 1'b1;
                    s_next.fsm = dacc_pkg::ST_IDLE;
                end
            end
            default:
                s_next.fsm = dacc_pkg::ST_IDLE;
        endcase
    end

    // state register; reset raises cs_n, both byte enables, clear_n and calibrate_request_n, other pins low
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_reg                          <= '0;
            s_reg.fsm                      <= dacc_pkg::ST_IDLE;
            s_reg.ctrl                     <= dacc_pkg::CTRL_RESET;
            s_reg.pins.cs_n                <= 1'b1;
            s_reg.pins.high_byte_enable_n  <= 1'b1;
            s_reg.pins.low_byte_enable_n   <= 1'b1;
            s_reg.pins.clear_n             <= 1'b1;
            s_reg.pins.calibrate_request_n <= 1'b1;
        end
        else
            s_reg <= s_next;
    end

    assign reg_rdata = s_reg.rdata;
    assign dac_pins  = s_reg.pins;

    // checks on the driven pins and the query result
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    AST_CAL_PULSE: assert property (
        $fell(s_reg.pins.calibrate_request_n)
        |=> !s_reg.pins.calibrate_request_n [*7] ##1 s_reg.pins.calibrate_request_n)
        else $error("calibrate pulse width wrong");
    AST_LEN_PINS: assert property (
        !s_reg.pins.cs_n && !s_reg.pins.serial_select_n
        |-> s_reg.pins.data[dacc_pkg::PIN_LEN] == s_reg.ctrl[dacc_pkg::CTRL_LEN18]
            && s_reg.pins.data[7:3] == '0)
        else $error("length pin or unused data pins wrong");
    AST_CLEAR_TARGET: assert property (
        !s_reg.pins.clear_n
        |-> s_reg.pins.low_byte_enable_n == s_reg.ctrl[dacc_pkg::CTRL_CLR_MID])
        else $error("clear target not driven during clear");
    AST_LOAD_AFTER_WORD: assert property (
        s_reg.pins.second_rank_load |-> s_reg.pins.cs_n && busy)
        else $error("load raised during a strobe");
    AST_CAL_FOLLOWS_LOAD: assert property (
        $fell(s_reg.pins.second_rank_load) && $past(s_reg.pend_cal)
        |-> $fell(s_reg.pins.calibrate_request_n))
        else $error("calibrate did not follow the parked load");
    AST_PREP_ZERO: assert property (
        s_reg.pend_cal && !s_reg.pins.cs_n && !s_reg.pins.serial_select_n
        |-> !s_reg.pins.data[dacc_pkg::PIN_SDATA])
        else $error("prep word not negative full scale");
    AST_STROBE_LOW: assert property (
        $fell(s_reg.pins.cs_n) |=> !s_reg.pins.cs_n [*4] ##1 s_reg.pins.cs_n)
        else $error("strobe low time wrong");
    AST_QUERY_RESULT: assert property (
        $rose(s_reg.pins.high_byte_enable_n) && s_reg.query_done
        && $past(s_reg.fsm == dacc_pkg::ST_QUERY)
        |-> s_reg.query_res == $past(st_sync.calibration_valid))
        else $error("query result not sampled at end");

    COV_SERIAL: cover property (
        !s_reg.pins.serial_select_n && $rose(s_reg.pins.second_rank_load));
    COV_BYTE: cover property (
        s_reg.pins.serial_select_n && !s_reg.pins.low_byte_enable_n && !s_reg.pins.cs_n);
    COV_PREP_CAL: cover property (
        $fell(s_reg.pins.second_rank_load) && !s_reg.pins.calibrate_request_n);
    COV_QUERY: cover property ($rose(s_reg.query_done));

endmodule

/* test/dacc_dev_model.sv */
// behavioural model of the calibrating converter's digital front end
`timescale 1ns/10ps
module dacc_dev_model #(
    parameter int CAL_T_NS = 2000
) (
    input  wire dacc_pkg::dacc_pins_t pins,
    output dacc_pkg::dacc_in_t        st,
    output logic [17:0]               dac_code,
    output logic                      hold_sel
);
    logic [17:0] rank1_reg;
    logic        cal_run;
    logic        cal_ok;
    logic        out_bit;

    // power-up leaves the part uncalibrated
    initial
    begin
        rank1_reg = 18'h00000;
        cal_run = 1'b0;
        cal_ok = 1'b0;
        out_bit = 1'b0;
        dac_code = 18'h00000;
    end

    // first rank moves only on the strobe's rising edge
    always @(posedge pins.cs_n)
    begin
        if (!pins.serial_select_n)
        begin
            out_bit = pins.data[1] ? (pins.data[2] ? rank1_reg[17] : rank1_reg[15])
                                   : rank1_reg[0];
            if (pins.data[1])
                rank1_reg = pins.data[2] ? {rank1_reg[16:0], pins.data[0]}
                                         : {2'h0, rank1_reg[14:0], pins.data[0]};
            else if (pins.data[2])
                rank1_reg = {pins.data[0], rank1_reg[17:1]};
            else
                rank1_reg = {2'h0, pins.data[0], rank1_reg[15:1]};
        end
        else
        begin
            // byte enables load the first rank only outside serial mode
            if (!pins.high_byte_enable_n)
                rank1_reg[15:8] = pins.data;
            if (!pins.low_byte_enable_n)
                rank1_reg[7:0] = pins.data;
            rank1_reg[17:16] = 2'h0;
        end
    end

    // second rank: level latch, clear overrides, sequencer owns it in calibration
    always @*
    begin
        if (cal_run)
            dac_code = 18'h15555;
        else if (!pins.clear_n)
            dac_code = pins.low_byte_enable_n ? 18'h08000 : 18'h00000;
        else if (pins.second_rank_load)
            dac_code = rank1_reg;
    end

    // calibration run, then reload from the first rank and report valid
    always @(negedge pins.calibrate_request_n)
    begin
        cal_ok = 1'b0;
        cal_run = 1'b1;
        #(CAL_T_NS);
        cal_run = 1'b0;
        dac_code = rank1_reg;
        cal_ok = 1'b1;
    end

    // status pins: valid flag first, then the chain bit
    assign st = {cal_ok | (cal_run & !pins.high_byte_enable_n),
                 out_bit};
    assign hold_sel             = !cal_ok | cal_run;
endmodule

/* test/dacc_host_tb.sv */
// self-checking bench for the dac host controller
`timescale 1ns/10ps
module dacc_host_tb;
    logic                 sys_clk;
    logic                 reset_n;
    logic [7:0]           reg_addr;
    logic [31:0]          reg_wdata;
    logic                 reg_wr;
    logic                 reg_rd;
    logic [31:0]          reg_rdata;
    dacc_pkg::dacc_pins_t dac_pins;
    dacc_pkg::dacc_in_t   dac_status;
    logic [17:0]          dac_code;
    logic                 hold_sel;
    logic [31:0]          rv;
    int                   n_fail;
    int                   num_checks;

    dacc_host u_dacc_host (
        .sys_clk    (sys_clk),
        .reset_n    (reset_n),
        .reg_addr   (reg_addr),
        .reg_wdata  (reg_wdata),
        .reg_wr     (reg_wr),
        .reg_rd     (reg_rd),
        .reg_rdata  (reg_rdata),
        .dac_pins   (dac_pins),
        .dac_status (dac_status)
    );

    dacc_dev_model u_dacc_dev_model (
        .pins     (dac_pins),
        .st       (dac_status),
        .dac_code (dac_code),
        .hold_sel (hold_sel)
    );

    // 125 MHz clock
    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // one-cycle write strobe, one idle edge after it
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask

    // one-cycle read strobe, data taken in the following cycle
    task automatic rd(input logic [7:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
        @(posedge sys_clk);
    endtask

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: register %h, wanted %h", $time, got, exp);
        end
    endtask

    task automatic chk_dac(input logic [17:0] exp);
        num_checks++;
        if (dac_code !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: dac code %h, wanted %h", $time, dac_code, exp);
        end
    endtask

    // poll busy with a bound
    task automatic wait_idle;
        int i;
        for (i = 0; i < 400; i++)
        begin
            rd(dacc_pkg::ADDR_STATUS);
            if (rv[0] === 1'b0)
                break;
        end
        chk_reg(rv[0], 32'h0);
    endtask

    task automatic run(input logic [31:0] ctrl, input logic [31:0] d, input logic [31:0] cmd);
        wr(dacc_pkg::ADDR_CTRL, ctrl);
        wr(dacc_pkg::ADDR_DATA, d);
        wr(dacc_pkg::ADDR_CMD, cmd);
        wait_idle();
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // watchdog
    initial
    begin
        #100000;
        n_fail++;
        print_verdict();
    end

    initial
    begin
        reset_n = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        n_fail = 0;
        num_checks = 0;
        repeat (20) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        rd(dacc_pkg::ADDR_CTRL);
        chk_reg(rv, 32'h3);
        rd(8'h14);
        chk_reg(rv, 32'h0);
        rd(dacc_pkg::ADDR_STATUS);
        chk_reg(rv & 32'h3, 32'h0);
        chk_reg(hold_sel, 32'h1);
        $display("test reset done");
        run(32'h13, 32'h0a5c3, 32'h1);
        chk_dac(18'h0a5c3);
        run(32'h03, 32'h01234, 32'h1);
        chk_dac(18'h0a5c3);
        rd(dacc_pkg::ADDR_CHAIN);
        chk_reg(rv & 32'hffff, 32'ha5c3);
        run(32'h03, 32'h01234, 32'h2);
        chk_dac(18'h01234);
        run(32'h15, 32'h2a5c3, 32'h1);
        chk_dac(18'h2a5c3);
        $display("test serial done");
        run(32'h10, 32'h0beef, 32'h1);
        chk_dac(18'h0beef);
        run(32'h00, 32'h0beef, 32'h4);
        chk_dac(18'h00000);
        run(32'h00, 32'h0beef, 32'h2);
        chk_dac(18'h0beef);
        run(32'h08, 32'h0beef, 32'h4);
        chk_dac(18'h08000);
        run(32'h0b, 32'h0beef, 32'h2);
        chk_dac(18'h0beef);
        run(32'h0b, 32'h0beef, 32'h4);
        chk_dac(18'h08000);
        $display("test clear done");
        run(32'h23, 32'h0beef, 32'h8);
        wr(dacc_pkg::ADDR_CMD, 32'h10);
        wait_idle();
        chk_reg(rv[3:2], 32'h3);
        repeat (4) @(posedge sys_clk);
        rd(dacc_pkg::ADDR_STATUS);
        chk_reg(rv[1], 32'h0);
        chk_reg(hold_sel, 32'h1);
        chk_dac(18'h15555);
        repeat (300) @(posedge sys_clk);
        rd(dacc_pkg::ADDR_STATUS);
        chk_reg(rv[1], 32'h1);
        chk_reg(hold_sel, 32'h0);
        chk_dac(18'h00000);
        $display("test calibration done");
        print_verdict();
    end
endmodule
